// ---- verilog/chd_read_path.sv ----
// Behaviour
// - Word size is length/4; zero skipped
// - Control-B cleared, then filled by fetch
// - Enabled channel waits for handshake requests
// - Host handshake requests pace the transfer
// - Different layers allow concurrent read and write
// - Rounding option pads blocks to whole words
// - Card bus: clock, command, four data; this module has only clock and four data pins
// - One data line until initialisation done
// - Register selects card slot and width
// - Handshake enable bit turns on requests
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`default_nettype none
module chd_read_path (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic card_clk,
  input wire logic [3:0] card_data,
  output logic [1:0] card_slot_sel,
  output logic card_bus_4bit,
  output logic card_clk_stall,
  output logic dma_req
);
  // Bus handshake state
  logic ack_r, rd_go, wr_go;
  logic [31:0] rd_mux, be_mask, wval;
  // Software-visible settings
  logic [1:0] mode_r, chunk_r, slot_r, width_r;
  logic [11:0] blk_len_r;
  logic [15:0] blk_cnt_r;
  logic round_r, hs_en_r;
  logic [3:0] irq_en_r; // Stored only, drives nothing
  // Sticky status
  logic dma_done_r, xfer_done_r, overrun_r, all_rx_r, stat_clr;
  // Link sampling
  logic s_clk, clk_d_r, rise;
  logic [3:0] s_data;
  // Receiver
  chd_pkg::chd_rx_state_e rx_state_r;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] nib_r, nib_nxt;
  logic [11:0] byte_cnt_r;
  logic [15:0] blks_left_r;
  logic [4:0] crc_cnt_r;
  logic [23:0] word_r; // Lower three bytes of the word in packing
  logic [1:0] bpos_r;
  logic byte_done, last_byte, tail, start_seen;
  // FIFO side
  logic push, pop, full, empty;
  logic [31:0] push_data, pad_word, head;
  logic [4:0] count, chunk_words;

  // One wait cycle per access keeps decode simple
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign rd_go = avs_read & ack_r;
  assign wr_go = avs_write & ack_r;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // Merge enabled lanes over current contents
  assign wval = (rd_mux & ~be_mask) | (avs_writedata & be_mask);

  // Access acknowledge toggles after one wait
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  // Read multiplexer; unmapped reads return zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      chd_pkg::OFS_MODE: rd_mux[1:0] = mode_r;
      chd_pkg::OFS_BLOCK:
      begin
        rd_mux[chd_pkg::BLK_LEN_LSB +: chd_pkg::BLK_LEN_W] = blk_len_r;
        rd_mux[chd_pkg::BLK_CNT_LSB +: chd_pkg::BLK_CNT_W] = blk_cnt_r;
      end
      chd_pkg::OFS_DMA_CFG:
      begin
        rd_mux[chd_pkg::DMA_CHUNK_LSB +: 2] = chunk_r;
        rd_mux[chd_pkg::DMA_ROUND_BIT] = round_r;
        rd_mux[chd_pkg::DMA_HS_EN_BIT] = hs_en_r;
      end
      chd_pkg::OFS_SLOT_WIDTH:
      begin
        rd_mux[chd_pkg::SLOT_LSB +: 2] = slot_r;
        rd_mux[chd_pkg::WIDTH_LSB +: 2] = width_r;
      end
      chd_pkg::OFS_STATUS:
      begin
        rd_mux[chd_pkg::STAT_EMPTY_BIT] = empty;
        rd_mux[chd_pkg::STAT_DMA_DONE_BIT] = dma_done_r;
        rd_mux[chd_pkg::STAT_XFER_DONE_BIT] = xfer_done_r;
        rd_mux[chd_pkg::STAT_OVERRUN_BIT] = overrun_r;
      end
      chd_pkg::OFS_IRQ_EN: rd_mux[3:0] = irq_en_r;
      chd_pkg::OFS_RX_FIFO: rd_mux = head;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack_r)
      avs_readdata <= rd_mux;
  end

  // Configuration writes
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // All-zero start for handshake and rounding
      mode_r <= 2'h0;
      blk_len_r <= chd_pkg::RST_BLK_LEN;
      blk_cnt_r <= chd_pkg::RST_BLK_CNT;
      chunk_r <= 2'h0;
      round_r <= 1'b0;
      hs_en_r <= 1'b0;
      slot_r <= 2'h0;
      width_r <= 2'h0;
      irq_en_r <= 4'h0;
    end
    else if (wr_go)
    begin
      case (avs_address)
        chd_pkg::OFS_MODE: mode_r <= wval[1:0];
        chd_pkg::OFS_BLOCK:
        begin
          blk_len_r <= wval[chd_pkg::BLK_LEN_LSB +: chd_pkg::BLK_LEN_W];
          blk_cnt_r <= wval[chd_pkg::BLK_CNT_LSB +: chd_pkg::BLK_CNT_W];
        end
        chd_pkg::OFS_DMA_CFG:
        begin
          chunk_r <= wval[chd_pkg::DMA_CHUNK_LSB +: 2];
          round_r <= wval[chd_pkg::DMA_ROUND_BIT];
          hs_en_r <= wval[chd_pkg::DMA_HS_EN_BIT];
        end
        chd_pkg::OFS_SLOT_WIDTH:
        begin
          slot_r <= wval[chd_pkg::SLOT_LSB +: 2];
          // Width stays one line until init is declared
          if (mode_r[chd_pkg::MODE_INIT_DONE_BIT])
            width_r <= wval[chd_pkg::WIDTH_LSB +: 2];
          else
            width_r <= 2'h0;
        end
        chd_pkg::OFS_IRQ_EN: irq_en_r <= wval[3:0];
        default: irq_en_r <= irq_en_r;
      endcase
    end
  end

  // Card-side pins drive from registers
  assign card_slot_sel = slot_r;
  assign card_bus_4bit = width_r == chd_pkg::WIDTH_4BIT;

  // Link clock and data pass two flops first
  chd_sync #(.W(5)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .din({card_clk, card_data}),
    .dout({s_clk, s_data})
  );

  // Third stage for edge detection
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      clk_d_r <= 1'b0;
    else
      clk_d_r <= s_clk;
  end
  assign rise = s_clk & ~clk_d_r;

  // Bit and byte assembly, MSB first
  always_comb
  begin
    if (card_bus_4bit)
    begin
      shift_nxt = {shift_r[3:0], s_data};
      nib_nxt = nib_r + 3'h4;
    end
    else
    begin
      shift_nxt = {shift_r[6:0], s_data[0]};
      nib_nxt = nib_r + 3'h1;
    end
  end
  assign byte_done = rise & (rx_state_r == chd_pkg::RX_DATA) & (nib_nxt == 3'h0);
  assign last_byte = byte_cnt_r == (blk_len_r - 12'h001);
  // Without rounding, bytes past the last whole word travel one per entry
  assign tail = ~round_r & (byte_cnt_r >= {blk_len_r[11:2], 2'h0});
  assign start_seen = card_bus_4bit ? (s_data == 4'h0) : ~s_data[0];

  // Partial word padded with zeros above
  always_comb
  begin
    case (bpos_r)
      2'h0: pad_word = {24'h00_0000, shift_nxt};
      2'h1: pad_word = {16'h0000, shift_nxt, word_r[7:0]};
      2'h2: pad_word = {8'h00, shift_nxt, word_r[15:0]};
      default: pad_word = {shift_nxt, word_r};
    endcase
  end

  // Short blocks give single-byte entries only, unless rounding is on
  assign push = byte_done & (tail | (bpos_r == 2'h3) | last_byte);
  assign push_data = tail ? {24'h00_0000, shift_nxt} : pad_word;

  // Receiver sequence per block
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_state_r <= chd_pkg::RX_IDLE;
      shift_r <= 8'h00;
      nib_r <= 3'h0;
      byte_cnt_r <= 12'h000;
      blks_left_r <= 16'h0000;
      crc_cnt_r <= 5'h00;
    end
    else if (wr_go & (avs_address == chd_pkg::OFS_CTRL) &
             avs_writedata[chd_pkg::CTRL_STOP_BIT])
      rx_state_r <= chd_pkg::RX_IDLE;
    else if (wr_go & (avs_address == chd_pkg::OFS_CTRL) &
             avs_writedata[chd_pkg::CTRL_START_BIT])
    begin
      rx_state_r <= chd_pkg::RX_WAIT;
      blks_left_r <= blk_cnt_r;
      byte_cnt_r <= 12'h000;
    end
    else if (rise)
    begin
      case (rx_state_r)
        chd_pkg::RX_WAIT:
        begin
          // Start bit on the active lines
          if (start_seen)
          begin
            rx_state_r <= chd_pkg::RX_DATA;
            nib_r <= 3'h0;
            byte_cnt_r <= 12'h000;
          end
        end
        chd_pkg::RX_DATA:
        begin
          shift_r <= shift_nxt;
          nib_r <= nib_nxt;
          if (nib_nxt == 3'h0)
          begin
            byte_cnt_r <= byte_cnt_r + 12'h001;
            if (last_byte)
            begin
              rx_state_r <= chd_pkg::RX_CRC;
              crc_cnt_r <= 5'h00;
            end
          end
        end
        chd_pkg::RX_CRC:
        begin
          // CRC is skipped, not checked
          crc_cnt_r <= crc_cnt_r + 5'h01;
          if (crc_cnt_r == chd_pkg::CRC_EDGES - 5'h01)
          begin
            if (blks_left_r <= 16'h0001)
              rx_state_r <= chd_pkg::RX_IDLE;
            else
              rx_state_r <= chd_pkg::RX_WAIT;
            blks_left_r <= blks_left_r - 16'h0001;
          end
        end
        default: rx_state_r <= chd_pkg::RX_IDLE;
      endcase
    end
  end

  // Word packing, little-endian byte order
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      word_r <= 24'h00_0000;
      bpos_r <= 2'h0;
    end
    else if (rx_state_r != chd_pkg::RX_DATA)
      bpos_r <= 2'h0;
    else if (byte_done & ~tail)
    begin
      case (bpos_r)
        2'h0: word_r[7:0] <= shift_nxt;
        2'h1: word_r[15:8] <= shift_nxt;
        2'h2: word_r[23:16] <= shift_nxt;
        default: word_r <= word_r;
      endcase
      bpos_r <= push ? 2'h0 : bpos_r + 2'h1;
    end
  end

  // Push and pop may meet in one cycle
  assign pop = rd_go & (avs_address == chd_pkg::OFS_RX_FIFO);
  chd_rx_fifo u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .push(push),
    .push_data(push_data),
    .pop(pop),
    .pop_data(head),
    .count(count),
    .full(full),
    .empty(empty)
  );

  // Request per chunk, or for a leftover after block end
  assign chunk_words = 5'h01 << chunk_r;
  assign dma_req = hs_en_r & ((count >= chunk_words) |
                   ((rx_state_r != chd_pkg::RX_DATA) & ~empty));

  // Stall request ahead of a full FIFO; margin covers sync lag
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      card_clk_stall <= 1'b0;
    else
      card_clk_stall <= mode_r[chd_pkg::MODE_READ_PROOF_BIT] &
        (count >= 5'(chd_pkg::FIFO_DEPTH) - chd_pkg::STALL_MARGIN);
  end

  // Status read clears only what it returned; a same-cycle event wins.
  // An event landing between capture and clear must not be lost.
  assign stat_clr = rd_go & (avs_address == chd_pkg::OFS_STATUS);
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      xfer_done_r <= 1'b0;
      dma_done_r <= 1'b0;
      overrun_r <= 1'b0;
      all_rx_r <= 1'b0;
    end
    else
    begin
      // Last block's end bit seen
      if (rise & (rx_state_r == chd_pkg::RX_CRC) &
          (crc_cnt_r == chd_pkg::CRC_EDGES - 5'h01) & (blks_left_r <= 16'h0001))
      begin
        xfer_done_r <= 1'b1;
        all_rx_r <= 1'b1;
      end
      else if (stat_clr & avs_readdata[chd_pkg::STAT_XFER_DONE_BIT])
        xfer_done_r <= 1'b0;
      // All data handed to the DMA
      if (all_rx_r & empty)
      begin
        dma_done_r <= 1'b1;
        all_rx_r <= 1'b0;
      end
      else if (stat_clr & avs_readdata[chd_pkg::STAT_DMA_DONE_BIT])
        dma_done_r <= 1'b0;
      // Lost word when not stalled in time
      if (push & full)
        overrun_r <= 1'b1;
      else if (stat_clr & avs_readdata[chd_pkg::STAT_OVERRUN_BIT])
        overrun_r <= 1'b0;
    end
  end
endmodule // chd_read_path
`default_nettype wire

// ---- verilog/chd_pkg.sv ----
`default_nettype none
// Shared constants of the card host read path
package chd_pkg;
  // Receive FIFO shape
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_BLOCK = 5'h04;
  localparam logic [4:0] OFS_DMA_CFG = 5'h08;
  localparam logic [4:0] OFS_SLOT_WIDTH = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_EN = 5'h14;
  localparam logic [4:0] OFS_RX_FIFO = 5'h18;
  localparam logic [4:0] OFS_CTRL = 5'h1C;
  // Mode register fields
  localparam int MODE_READ_PROOF_BIT = 0;
  localparam int MODE_INIT_DONE_BIT = 1;
  // Block register fields
  localparam int BLK_LEN_LSB = 0;
  localparam int BLK_LEN_W = 12;
  localparam int BLK_CNT_LSB = 16;
  localparam int BLK_CNT_W = 16;
  // DMA config fields
  localparam int DMA_CHUNK_LSB = 0;
  localparam int DMA_ROUND_BIT = 4;
  localparam int DMA_HS_EN_BIT = 8;
  // Slot and width fields
  localparam int SLOT_LSB = 0;
  localparam int WIDTH_LSB = 6;
  localparam logic [1:0] WIDTH_4BIT = 2'h2;
  // Status bits
  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_DMA_DONE_BIT = 1;
  localparam int STAT_XFER_DONE_BIT = 2;
  localparam int STAT_OVERRUN_BIT = 3;
  // Control bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  // Reset values
  localparam logic [11:0] RST_BLK_LEN = 12'h200;
  localparam logic [15:0] RST_BLK_CNT = 16'h0001;
  // Link timing: CRC16 edges plus end bit
  localparam logic [4:0] CRC_EDGES = 5'h11;
  localparam logic [4:0] STALL_MARGIN = 5'h02;
  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_WAIT = 2'h1,
    RX_DATA = 2'h2,
    RX_CRC = 2'h3
  } chd_rx_state_e;
endpackage
`default_nettype wire

// ---- verilog/chd_sync.sv ----
`default_nettype none
// Two-flop synchroniser for pin inputs
module chd_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // First stage, read only by the second
  logic [W-1:0] meta_r;

  // Both stages reset to zero
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // chd_sync
`default_nettype wire

// ---- verilog/chd_rx_fifo.sv ----
`default_nettype none
// Receive word FIFO in flip-flops
module chd_rx_fifo (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic push,
  input wire logic [chd_pkg::DATA_W-1:0] push_data,
  input wire logic pop,
  output logic [chd_pkg::DATA_W-1:0] pop_data,
  output logic [chd_pkg::FIFO_AW:0] count,
  output logic full,
  output logic empty
);
  // Storage addressed by pointer
  logic [chd_pkg::DATA_W-1:0] mem_r [chd_pkg::FIFO_DEPTH];
  logic [chd_pkg::FIFO_AW-1:0] wptr_r;
  logic [chd_pkg::FIFO_AW-1:0] rptr_r;
  logic [chd_pkg::FIFO_AW:0] cnt_r;
  logic do_push;
  logic do_pop;

  // Guarded: overfill and underflow are dropped
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign full = cnt_r == 5'(chd_pkg::FIFO_DEPTH);
  assign empty = cnt_r == 5'h00;
  assign count = cnt_r;
  assign pop_data = mem_r[rptr_r];

  // Data store, no reset needed
  always_ff @(posedge core_clk)
  begin
    if (do_push)
      mem_r[wptr_r] <= push_data;
  end

  // Pointers and fill level
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wptr_r <= 4'h0;
      rptr_r <= 4'h0;
      cnt_r <= 5'h00;
    end
    else
    begin
      if (do_push)
        wptr_r <= wptr_r + 4'h1;
      if (do_pop)
        rptr_r <= rptr_r + 4'h1;
      cnt_r <= cnt_r + 5'(do_push) - 5'(do_pop);
    end
  end
endmodule // chd_rx_fifo
`default_nettype wire

// ---- verification/chd_read_path_sva.sv ----
`default_nettype none
// Port checks of the read path, bound to the top module
module chd_read_path_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] card_slot_sel,
  input wire logic card_bus_4bit,
  input wire logic card_clk_stall,
  input wire logic dma_req
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  logic wacc; // Write with lane 0 enabled accepted at this edge
  logic init_q; // Last init-done value written
  assign wacc = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Track init-done so width changes can be judged
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      init_q <= 1'b0;
    else if (wacc && avs_address == chd_pkg::OFS_MODE)
      init_q <= avs_writedata[1];
  end
  property p_one_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  property p_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  property p_rd_hold;
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  property p_w4_src;
    $rose(card_bus_4bit) |-> $past(wacc && avs_address == chd_pkg::OFS_SLOT_WIDTH
      && avs_writedata[7:6] == chd_pkg::WIDTH_4BIT);
  endproperty
  property p_w4_init;
    $rose(card_bus_4bit) |-> init_q;
  endproperty
  property p_slot_src;
    !$stable(card_slot_sel) |-> $past(wacc && avs_address == chd_pkg::OFS_SLOT_WIDTH);
  endproperty
  property p_slot_val;
    wacc && avs_address == chd_pkg::OFS_SLOT_WIDTH |=> card_slot_sel == $past(avs_writedata[1:0]);
  endproperty
  property p_hs_off;
    avs_write && !avs_waitrequest && avs_byteenable[1] && avs_address == chd_pkg::OFS_DMA_CFG
      && !avs_writedata[8] |=> !dma_req;
  endproperty
  property p_rp_off;
    wacc && avs_address == chd_pkg::OFS_MODE && !avs_writedata[0] |=> ##1 !card_clk_stall;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
  a_idle: assert property (p_idle) else $error("wait while idle");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_w4_src: assert property (p_w4_src) else $error("width rose unasked");
  a_w4_init: assert property (p_w4_init) else $error("width before init");
  a_slot_src: assert property (p_slot_src) else $error("slot moved unasked");
  a_slot_val: assert property (p_slot_val) else $error("slot value wrong");
  a_hs_off: assert property (p_hs_off) else $error("request without enable");
  a_rp_off: assert property (p_rp_off) else $error("stall without mode");
  c_stall: cover property ($rose(card_clk_stall));
  c_req: cover property ($rose(dma_req));
  c_w4: cover property ($rose(card_bus_4bit));
endmodule // chd_read_path_sva
bind chd_read_path chd_read_path_sva u_sva (.core_clk(core_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .card_slot_sel(card_slot_sel), .card_bus_4bit(card_bus_4bit),
  .card_clk_stall(card_clk_stall), .dma_req(dma_req));
`default_nettype wire

// ---- verification/chd_card_model.sv ----
`default_nettype none
// Behavioural card sending read blocks
module chd_card_model (
  input wire logic core_clk,
  input wire logic card_clk_stall,
  output logic card_clk,
  output logic [3:0] card_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:127]; // Block bytes, filled by the bench
  // Clock parked low, lines pulled up
  initial
  begin
    card_clk = 1'b0;
    card_data = 4'hF;
  end
  // One link clock; waits while the host asks for a stall
  task automatic tick(input logic [3:0] d);
    while (card_clk_stall) @(posedge core_clk);
    card_data = d;
    #40 card_clk = 1'b1;
    #40 card_clk = 1'b0;
  endtask
  // Start bit, bytes high bit first, CRC slots, then idle gap
  task automatic send(input int base, input int n, input logic w4);
    tick(w4 ? 4'h0 : 4'hE);
    for (int i = base; i < base + n; i++)
      if (w4)
      begin
        tick(mem[i][7:4]);
        tick(mem[i][3:0]);
      end
      else
        for (int b = 7; b >= 0; b--) tick({3'h7, mem[i][b]});
    repeat (17) tick(4'hF); // CRC is not checked by the host
    card_data = 4'hF;
    #400;
  endtask
endmodule // chd_card_model
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
// Self-checking bench of the card host read path
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rstn, avs_read, avs_write, avs_waitrequest, card_clk;
  logic card_bus_4bit, card_clk_stall, dma_req;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, card_data;
  logic [1:0] card_slot_sel, slot;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 62542;
  int cyc = 0;
  logic [31:0] exp_q[$], msk_q[$], ent[$]; // Read notes, FIFO entries
  logic stall_seen = 1'b0;
  // Cases: length, block count, rounding, 4-bit bus, chunk code
  int c_len [4] = '{7, 7, 3, 64};
  int c_cnt [4] = '{2, 1, 1, 1};
  logic [3:0] c_rnd = 4'b1010;
  logic [3:0] c_w4 = 4'b0010;
  logic [3:0] c_ck = 4'b1000;
  chd_read_path dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .card_clk(card_clk), .card_data(card_data),
    .card_slot_sel(card_slot_sel), .card_bus_4bit(card_bus_4bit),
    .card_clk_stall(card_clk_stall), .dma_req(dma_req));
  chd_card_model card (.core_clk(core_clk), .card_clk_stall(card_clk_stall),
    .card_clk(card_clk), .card_data(card_data));
  // 100 MHz system clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Verdict and end of run
  task automatic end_of_test();
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Single comparison of any result
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Comparison of a pin level
  task automatic chk_pin(input string nm, input logic [31:0] e, input logic [31:0] s);
    chk(nm, e, s);
  endtask
  // Cycle ceiling, stall watch; the run needs about 6.5k cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (card_clk_stall === 1'b1)
      stall_seen <= 1'b1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  // Read data taken at the accepting edge against the oldest note
  always @(posedge core_clk)
  begin
    if (avs_read && avs_waitrequest === 1'b0)
    begin
      if (msk_q[0] != 32'h0)
        chk("readdata", exp_q[0] & msk_q[0], avs_readdata & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // One bus access held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    avs_byteenable <= wr ? 4'hF : 4'($random(seed)); // Reads ignore lanes
    // Answer sampled on the rising edge; release only after it
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Read with a note of the expected value and compare mask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  // Acts as the DMA: pops the window only while a request stands
  task automatic drain();
    while (ent.size() > 0)
    begin
      @(negedge core_clk);
      if (dma_req === 1'b1)
        rd(chd_pkg::OFS_RX_FIFO, ent.pop_front(), 32'hFFFF_FFFF);
    end
  endtask
  // FIFO entries of one block: whole words, then padded word or single bytes
  task automatic expect_block(input int base, input int len, input logic rnd);
    logic [31:0] w;
    for (int k = 0; k < len; k += 4)
    begin
      w = 32'h0;
      for (int j = 0; j < 4 && k + j < len; j++)
        if (k + 4 <= len || rnd)
          w[8*j +: 8] = card.mem[base + k + j];
        else
          ent.push_back({24'h0, card.mem[base + k + j]});
      if (k + 4 <= len || rnd)
        ent.push_back(w);
    end
  endtask
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    slot = 2'h0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk_pin("pins", 32'h0,
      {27'h0, card_slot_sel, card_bus_4bit, card_clk_stall, dma_req});
    rd(chd_pkg::OFS_BLOCK, 32'h0001_0200, 32'hFFFF_FFFF);
    rd(chd_pkg::OFS_STATUS, 32'h1, 32'hF);
    bus(1'b1, chd_pkg::OFS_SLOT_WIDTH, 32'h82);
    @(negedge core_clk);
    chk_pin("width", 32'h0, {31'h0, card_bus_4bit});
    bus(1'b1, chd_pkg::OFS_MODE, 32'h2);
    bus(1'b1, chd_pkg::OFS_SLOT_WIDTH, 32'h82);
    @(negedge core_clk);
    chk_pin("width", 32'h1, {31'h0, card_bus_4bit});
    bus(1'b1, 5'h1E, 32'h0);
    rd(chd_pkg::OFS_SLOT_WIDTH, 32'h82, 32'hFF);
    bus(1'b1, chd_pkg::OFS_MODE, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      slot = 2'($random(seed));
      bus(1'b1, chd_pkg::OFS_SLOT_WIDTH, {24'h0, c_w4[i], 5'h0, slot});
      @(negedge core_clk);
      chk_pin("slot", {30'h0, slot}, {30'h0, card_slot_sel});
      chk_pin("width", {31'h0, c_w4[i]}, {31'h0, card_bus_4bit});
      bus(1'b1, chd_pkg::OFS_DMA_CFG, {23'h0, i != 2, 3'h0, c_rnd[i], 3'h0, c_ck[i]});
      bus(1'b1, chd_pkg::OFS_BLOCK, {16'(c_cnt[i]), 4'h0, 12'(c_len[i])});
      rd(chd_pkg::OFS_STATUS, 32'h0, 32'h0);
      for (int k = 0; k < c_len[i] * c_cnt[i]; k++)
        card.mem[k] = 8'($random(seed));
      for (int b = 0; b < c_cnt[i]; b++)
        expect_block(b * c_len[i], c_len[i], c_rnd[i]);
      bus(1'b1, chd_pkg::OFS_CTRL, 32'h1);
      // Interrupt-enable register written after the transfer is armed, then read back
      bus(1'b1, chd_pkg::OFS_IRQ_EN, {28'h0, 4'(i + 1)});
      rd(chd_pkg::OFS_IRQ_EN, {28'h0, 4'(i + 1)}, 32'hFFFF_FFFF);
      fork
        for (int b = 0; b < c_cnt[i]; b++)
          card.send(b * c_len[i], c_len[i], c_w4[i]);
      join_none
      while (i == 3 && stall_seen !== 1'b1) @(posedge core_clk); // Fill until stall
      if (i != 2)
        drain();
      wait fork;
      if (i == 2)
      begin
        repeat (20) @(negedge core_clk);
        chk_pin("req", 32'h0, {31'h0, dma_req});
        bus(1'b1, chd_pkg::OFS_DMA_CFG, 32'h100);
        drain();
      end
      repeat (20) @(posedge core_clk);
      rd(chd_pkg::OFS_STATUS, 32'h7, 32'hF);
      @(negedge core_clk);
      chk_pin("req", 32'h0, {31'h0, dma_req});
    end
    chk_pin("stall", 32'h1, {31'h0, stall_seen});
    end_of_test();
  end
endmodule // tb
`default_nettype wire
